// file: shared/sadc_pkg.sv
// shared constants and types for the converter serial frame control
package sadc_pkg;
    // ----------------------------------------------------------------
    // data format
    // ----------------------------------------------------------------
    localparam int          RES_W      = 14;          // result width
    localparam logic [13:0] ABORT_CODE = 14'h3f80;    // code after abort
    localparam logic [3:0]  PIN_IDLE   = 4'he;        // {pwd,fs,cs_n,sclk}

    // ----------------------------------------------------------------
    // frame edge positions (falls counted from frame start, rises from the first fall)
    // ----------------------------------------------------------------
    localparam logic [4:0] WAKE_RISE  = 5'h08;        // leave nap
    localparam logic [4:0] TRACK_RISE = 5'h09;        // open sample
    localparam logic [4:0] DATA_BITS  = 5'h0e;        // bits shifted out
    localparam logic [4:0] CONV_FALL  = 5'h10;        // start conversion
    localparam logic [4:0] CNT_MAX    = 5'h1f;        // counter ceiling

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_NS       = 4;                  // 250 MHz clock
    localparam int CONV_TIME_NS = 365;                // longest conversion
    localparam int CONV_CYCLES  = CONV_TIME_NS / CLK_NS;
    localparam int PD_TIME_NS   = 7200;               // least low for power-down
    localparam int PD_CYCLES    = (PD_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int INIT_CONV    = 4;                  // conversions up to the first valid result

    // frame sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DATA,
        ST_TRACK,
        ST_HOLD
    } sadc_state_t;
endpackage : sadc_pkg

// file: shared/sadc_conv_if.sv
// link between frame sequencer and conversion engine
`timescale 1ns/1ps
`default_nettype none
interface sadc_conv_if;
    logic        start;        // begin conversion pulse
    logic        abort;        // abort running conversion pulse
    logic        soft_rst;     // device reset level
    logic [13:0] sample_data;  // digitised input value
    logic        busy;         // conversion running
    logic        done;         // conversion finished pulse
    logic [13:0] result;       // last completed result
    logic        valid;        // result past start-up conversions

    modport ctrl (output start, abort, soft_rst, sample_data,
                  input  busy, done, result, valid);
    modport eng  (input  start, abort, soft_rst, sample_data,
                  output busy, done, result, valid);
endinterface : sadc_conv_if
`default_nettype wire

// file: rtl/sadc_conv_engine.sv
// internally timed conversion engine with start-up validity count
`timescale 1ns/1ps
`default_nettype none
module sadc_conv_engine (
    input  wire logic clk_i,
    input  wire logic rst_i,
    sadc_conv_if.eng  cif
);
    import sadc_pkg::*;

    logic [6:0] timer;     // cycles left in conversion
    logic [2:0] init_cnt;  // completed conversions since reset
    logic [6:0] busy_run;  // helper: cycles busy so far

    // ----------------------------------------------------------------
    // conversion timer
    // ----------------------------------------------------------------
    // runs on the system clock, no serial clock needed
    always_ff @(posedge clk_i) begin
        cif.done <= 1'b0;
        if (rst_i || cif.soft_rst) begin
            cif.busy <= 1'b0;
            timer    <= 7'h0;
        end else if (cif.start) begin
            cif.busy <= 1'b1;
            timer    <= 7'(CONV_CYCLES - 1);
        end else if (cif.abort) begin
            cif.busy <= 1'b0;
        end else if (cif.busy) begin
            if (timer == 7'h0) begin
                cif.busy <= 1'b0;
                cif.done <= 1'b1;
            end else begin
                timer <= timer - 7'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // result capture and start-up count
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || cif.soft_rst) begin
            cif.result <= 14'h0;
            init_cnt   <= 3'h0;
            cif.valid  <= 1'b0;
        end else if (cif.done) begin
            cif.result <= cif.sample_data;
            if (init_cnt != 3'(INIT_CONV)) begin
                init_cnt <= init_cnt + 3'h1;
            end
            cif.valid <= (init_cnt >= 3'(INIT_CONV - 1));
        end
    end

    // helper counter of busy cycles
    always_ff @(posedge clk_i) begin
        if (rst_i || !cif.busy) begin
            busy_run <= 7'h0;
        end else begin
            busy_run <= busy_run + 7'h1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    conv_len_a: assert property (cif.done |-> $past(busy_run) == 7'(CONV_CYCLES - 1))
        else $error("conversion length wrong");
    busy_start_a: assert property (cif.start && !cif.soft_rst |=>
        cif.busy && timer == 7'(CONV_CYCLES - 1))
        else $error("busy did not follow start");
    abort_stop_a: assert property (cif.abort && !cif.start && !cif.soft_rst |=> !cif.busy)
        else $error("abort left busy high");
    init_valid_a: assert property ($rose(cif.valid) |-> $past(cif.done))
        else $error("valid rose without conversion");
endmodule : sadc_conv_engine
`default_nettype wire

// file: rtl/sadc_frame_ctrl.sv
// serial frame control of a sampling converter
`timescale 1ns/1ps
`default_nettype none
module sadc_frame_ctrl #(
    parameter int RES_W_P = 14                      // result width
) (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     sclk_i,
    input  wire logic                     cs_n_i,
    input  wire logic                     frame_sync_i,
    input  wire logic                     powerdown_reset_n_i,
    input  wire logic [sadc_pkg::RES_W-1:0] conv_data_i,
    output var  logic                     serial_out_o,
    output var  logic                     serial_out_oe_o,
    output var  logic                     busy_o,
    output var  logic                     nap_o,
    output var  logic                     track_o,
    output var  logic                     powered_down_o,
    output var  logic                     data_valid_o
);
    import sadc_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    sadc_conv_if cif ();                   // engine link
    logic [3:0]  sync1;                    // first sync stage
    logic [3:0]  sync2;                    // second sync stage
    logic [3:0]  prev;                     // delayed for edges
    logic        sclk_rise;                // serial clock rising
    logic        sclk_fall;                // serial clock falling
    logic        cs_fall;                  // chip select asserted
    logic        cs_rise;                  // chip select released
    logic        fs_rise;                  // frame sync rising
    logic        cs_low;                   // chip select level
    logic        fs_high;                  // frame sync level
    logic        pwd_low;                  // power-down/reset level
    logic        frame_start;              // new frame event
    logic [10:0] pd_cnt;                   // low-time counter
    logic [4:0]  fall_cnt;                 // falling edges in frame
    logic [4:0]  rise_cnt;                 // rising edges after first fall
    logic [RES_W-1:0] load_word;           // word for this frame
    logic [RES_W-1:0] shreg;               // output shifter
    sadc_state_t state;                    // frame phase
    sadc_state_t next_state;               // phase for next cycle
    logic        start_conv;               // sample window closes

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    // two stages, then a delayed copy for edge detection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1 <= PIN_IDLE;
            sync2 <= PIN_IDLE;
            prev  <= PIN_IDLE;
        end else begin
            sync1 <= {powerdown_reset_n_i, frame_sync_i, cs_n_i, sclk_i};
            sync2 <= sync1;
            prev  <= sync2;
        end
    end

    // edge and level decode
    assign sclk_rise = sync2[0] & ~prev[0];
    assign sclk_fall = ~sync2[0] & prev[0];
    assign cs_fall   = ~sync2[1] & prev[1];
    assign cs_rise   = sync2[1] & ~prev[1];
    assign fs_rise   = sync2[2] & ~prev[2];
    assign cs_low    = ~sync2[1];
    assign fs_high   = sync2[2];
    assign pwd_low   = ~sync2[3];

    // spi frames while frame_sync held high, dsp frames on its rise
    assign frame_start = !pwd_low &&
                         ((cs_fall && fs_high) ||
                          (fs_rise && cs_low));

    // ----------------------------------------------------------------
    // power-down / reset
    // ----------------------------------------------------------------
    // low level resets at once, long low level powers down
    always_ff @(posedge clk_i) begin
        if (rst_i || !pwd_low) begin
            pd_cnt <= 11'h0;
        end else if (pd_cnt != 11'(PD_CYCLES)) begin
            pd_cnt <= pd_cnt + 11'h1;
        end
    end

    // power-down flag follows the counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            powered_down_o <= 1'b0;
        end else begin
            powered_down_o <= pwd_low && (pd_cnt == 11'(PD_CYCLES));
        end
    end

    // ----------------------------------------------------------------
    // engine link
    // ----------------------------------------------------------------
    assign cif.soft_rst    = pwd_low;
    assign cif.abort       = frame_start && cif.busy;
    assign cif.start       = start_conv;
    assign cif.sample_data = conv_data_i;

    sadc_conv_engine u_engine (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .cif   (cif.eng)
    );

    // ----------------------------------------------------------------
    // frame sequencer
    // ----------------------------------------------------------------
    // phase decode; power-down low outranks frame start, which outranks every other event
    always_comb begin
        next_state = state;
        start_conv = 1'b0;
        if (pwd_low) begin
            next_state = ST_IDLE;
        end else if (frame_start) begin
            next_state = ST_DATA;
        end else begin
            case (state)
                ST_DATA: begin
                    if (cs_rise) begin
                        next_state = ST_IDLE;              // abort before sample
                    end else if (sclk_rise && fall_cnt != 5'h0 &&
                                 rise_cnt == TRACK_RISE - 5'h1) begin
                        next_state = ST_TRACK;
                    end
                end
                ST_TRACK: begin
                    if (cs_rise || (sclk_fall && fall_cnt == CONV_FALL - 5'h1)) begin
                        next_state = ST_HOLD;
                        start_conv = 1'b1;
                    end
                end
                ST_HOLD: next_state = ST_HOLD;             // waits for next frame
                ST_IDLE: next_state = ST_IDLE;
                default: next_state = ST_IDLE;
            endcase
        end
    end

    // phase register and sample window output
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state   <= ST_IDLE;
            track_o <= 1'b0;
        end else begin
            state   <= next_state;
            track_o <= (next_state == ST_TRACK);
        end
    end

    // ----------------------------------------------------------------
    // edge counters
    // ----------------------------------------------------------------
    // falling edges number the clocks; rises count once clock one ended
    always_ff @(posedge clk_i) begin
        if (rst_i || pwd_low || frame_start) begin
            fall_cnt <= 5'h0;
            rise_cnt <= 5'h0;
        end else if (state != ST_IDLE) begin
            if (sclk_fall && fall_cnt != CNT_MAX) begin
                fall_cnt <= fall_cnt + 5'h1;
            end
            if (sclk_rise && fall_cnt != 5'h0 && rise_cnt != CNT_MAX) begin
                rise_cnt <= rise_cnt + 5'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // serial data out
    // ----------------------------------------------------------------
    // frame that aborts a conversion sends the fixed code
    assign load_word = cif.busy ? ABORT_CODE : cif.result;

    // msb at start, then one bit per rising edge up to bit fourteen
    always_ff @(posedge clk_i) begin
        if (rst_i || pwd_low) begin
            shreg        <= '0;
            serial_out_o <= 1'b0;
        end else if (frame_start) begin
            shreg        <= load_word;
            serial_out_o <= load_word[RES_W-1];
        end else if (state != ST_IDLE && sclk_rise && fall_cnt != 5'h0 &&
                     rise_cnt < DATA_BITS - 5'h1) begin
            shreg        <= {shreg[RES_W-2:0], 1'b0};
            serial_out_o <= shreg[RES_W-2];
        end
    end

    // driver enabled only while selected and out of reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serial_out_oe_o <= 1'b0;
        end else begin
            serial_out_oe_o <= cs_low && !pwd_low;
        end
    end

    // ----------------------------------------------------------------
    // status outputs
    // ----------------------------------------------------------------
    // nap from conversion end until the eighth rising edge
    always_ff @(posedge clk_i) begin
        if (rst_i || pwd_low) begin
            nap_o <= 1'b0;
        end else if (cif.done) begin
            nap_o <= 1'b1;
        end else if (state == ST_DATA && sclk_rise && fall_cnt != 5'h0 &&
                     rise_cnt == WAKE_RISE - 5'h1) begin
            nap_o <= 1'b0;
        end
    end

    // registered copies of engine status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_o       <= 1'b0;
            data_valid_o <= 1'b0;
        end else begin
            busy_o       <= cif.busy;
            data_valid_o <= cif.valid;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_counts_clear;
        ##1 (fall_cnt == 5'h0 && rise_cnt == 5'h0);
    endsequence

    // phase and window output change on the same edge
    sequence s_track_open;
        ##1 (state == ST_TRACK && track_o);
    endsequence

    count_clear_a: assert property (frame_start |-> s_counts_clear)
        else $error("counters not cleared");
    track_ninth_a: assert property (state == ST_DATA && sclk_rise && fall_cnt != 5'h0 &&
        rise_cnt == 5'h8 && !cs_rise && !frame_start && !pwd_low |-> s_track_open)
        else $error("tracking missed ninth edge");
    conv_sixteenth_a: assert property (state == ST_TRACK && sclk_fall && fall_cnt == 5'hf &&
        !frame_start && !pwd_low |-> cif.start ##2 busy_o)
        else $error("conversion not started");
    msb_start_a: assert property (frame_start |=> serial_out_o == $past(load_word[RES_W-1]))
        else $error("msb not presented");
    abort_code_a: assert property (frame_start && cif.busy |=> shreg == ABORT_CODE)
        else $error("abort code not loaded");
    oe_release_a: assert property (!cs_low |=> !serial_out_oe_o)
        else $error("serial_out driven while deselected");
    wake_eighth_a: assert property (nap_o && state == ST_DATA && sclk_rise && fall_cnt != 5'h0 &&
        rise_cnt == 5'h7 && !pwd_low && !cif.done |=> !nap_o)
        else $error("nap not left");
    pd_release_a: assert property (!pwd_low |=> !powered_down_o)
        else $error("power-down without low level");
endmodule : sadc_frame_ctrl
`default_nettype wire

// file: tb/sadc_host_model.sv
// serial host model: frames the link and collects the result bits
`timescale 1ns/1ps
`default_nettype none
module sadc_host_model (
    input  wire logic clk_i,
    input  wire logic serial_out_i,
    input  wire logic serial_out_oe_i,
    output var  logic sclk_o,
    output var  logic cs_n_o,
    output var  logic frame_sync_o
);
    logic last_bit;  // last level driven on serial_out
    logic sdo_line;  // resolved pin level seen by the host

    // idle pins: clock parked low, chip select high, frame_sync high
    initial begin
        sclk_o       = 1'b0;
        cs_n_o       = 1'b1;
        frame_sync_o = 1'b1;
        last_bit     = 1'b0;
    end

    // released line shows the inverse of the last driven bit
    always @(posedge clk_i) begin
        if (serial_out_oe_i) begin
            last_bit <= serial_out_i;
        end
    end
    assign sdo_line = serial_out_oe_i ? serial_out_i : ~last_bit;

    // one frame; bit 13-k of the word is taken just before fall k+1
    task automatic run(input logic dsp, input int ncyc, output logic [13:0] word);
        int i;
        word = 14'h0000;
        @(negedge clk_i);
        if (dsp) begin
            frame_sync_o = 1'b0;
            repeat (4) @(negedge clk_i);
            cs_n_o = 1'b0;
            repeat (4) @(negedge clk_i);
            frame_sync_o = 1'b1;
            repeat (4) @(negedge clk_i);
            frame_sync_o = 1'b0;
        end else begin
            cs_n_o = 1'b0;
        end
        repeat (8) @(negedge clk_i);
        for (i = 0; i < ncyc; i++) begin
            sclk_o = 1'b1;
            repeat (8) @(negedge clk_i);
            if (i < 14) begin
                word[13-i] = sdo_line;
            end
            sclk_o = 1'b0;
            repeat (8) @(negedge clk_i);
        end
        // clock stays parked while the conversion runs
        repeat (4) @(negedge clk_i);
        cs_n_o = 1'b1;
        repeat (4) @(negedge clk_i);
        frame_sync_o = 1'b1;
    endtask : run
endmodule : sadc_host_model
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the converter frame control
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sadc_pkg::*;
    logic             clk_i, rst_i, powerdown_reset_n_i;
    logic [RES_W-1:0] conv_data_i;  // value handed to the next conversion
    logic             sclk_i, cs_n_i, frame_sync_i;
    logic             serial_out_o, serial_out_oe_o, busy_o, nap_o;
    logic             track_o, powered_down_o, data_valid_o;
    logic [13:0]      prev;         // result the next frame should carry
    logic             trk_seen;     // sample window seen after wake
    int               n_errors, n_tests, busy_cnt, last_busy;

    sadc_frame_ctrl i_sadc_frame_ctrl (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk_i),
        .cs_n_i(cs_n_i), .frame_sync_i(frame_sync_i), .powerdown_reset_n_i(powerdown_reset_n_i),
        .conv_data_i(conv_data_i), .serial_out_o(serial_out_o),
        .serial_out_oe_o(serial_out_oe_o), .busy_o(busy_o), .nap_o(nap_o), .track_o(track_o),
        .powered_down_o(powered_down_o), .data_valid_o(data_valid_o));
    sadc_host_model i_sadc_host_model (.clk_i(clk_i), .serial_out_i(serial_out_o),
        .serial_out_oe_i(serial_out_oe_o), .sclk_o(sclk_i), .cs_n_o(cs_n_i),
        .frame_sync_o(frame_sync_i));

    // 250 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // busy length meter and sample window watcher
    always @(posedge clk_i) begin
        if (busy_o === 1'b1) begin
            busy_cnt <= busy_cnt + 1;
        end else if (busy_cnt != 0) begin
            last_busy <= busy_cnt;
            busy_cnt  <= 0;
        end
        if (track_o === 1'b1 && nap_o === 1'b0) begin
            trk_seen <= 1'b1;
        end
    end

    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t value got %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    // bounded wait for busy to reach a level
    task automatic wait_busy(input logic lvl, input int lim);
        int k;
        k = 0;
        while (busy_o !== lvl && k < lim) begin
            @(negedge clk_i);
            k++;
        end
        chk_bit(busy_o, lvl);
    endtask : wait_busy

    // full frame plus the conversion that follows it
    task automatic conv_frame(input logic dsp, input logic [13:0] nxt);
        logic [13:0] w;
        conv_data_i = nxt;
        trk_seen    = 1'b0;
        i_sadc_host_model.run(dsp, 16, w);
        chk_val(w, prev);
        chk_bit(trk_seen, 1'b1);
        chk_bit(track_o, 1'b0);
        repeat (6) @(negedge clk_i);
        chk_bit(serial_out_oe_o, 1'b0);
        wait_busy(1'b1, 20);
        wait_busy(1'b0, 200);
        // the busy meter stores its count one clock after busy falls
        @(negedge clk_i);
        chk_val(last_busy, CONV_CYCLES);
        chk_bit(nap_o, 1'b1);
        prev = nxt;
        repeat (4) @(negedge clk_i);
    endtask : conv_frame

    task automatic t_spi();
        int k;
        chk_bit(serial_out_oe_o, 1'b0);
        for (k = 0; k < 4; k++) begin
            chk_bit(data_valid_o, 1'b0);
            conv_frame(1'b0, 14'h1a5c + 14'(k * 819));
        end
        chk_bit(data_valid_o, 1'b1);
        $display("test spi done");
    endtask : t_spi

    task automatic t_dsp();
        conv_frame(1'b1, 14'h0f0f);
        conv_frame(1'b1, 14'h3001);
        $display("test dsp done");
    endtask : t_dsp

    // frame cut before the sample window, then a clean frame
    task automatic t_short();
        logic [13:0] w;
        i_sadc_host_model.run(1'b0, 4, w);
        chk_val(w[13:10], prev[13:10]);
        repeat (60) @(negedge clk_i);
        chk_bit(busy_o, 1'b0);
        conv_frame(1'b0, 14'h2b6d);
        $display("test short done");
    endtask : t_short

    // new frame started in mid conversion
    task automatic t_abort(input logic dsp);
        logic [13:0] w;
        conv_data_i = 14'h155a;
        i_sadc_host_model.run(dsp, 16, w);
        chk_val(w, prev);
        wait_busy(1'b1, 20);
        repeat (10) @(negedge clk_i);
        conv_data_i = 14'h2aa5;
        i_sadc_host_model.run(dsp, 16, w);
        chk_val(w, ABORT_CODE);
        chk_bit(last_busy < CONV_CYCLES, 1'b1);
        wait_busy(1'b1, 20);
        wait_busy(1'b0, 200);
        prev = 14'h2aa5;
        repeat (4) @(negedge clk_i);
        conv_frame(dsp, 14'h0bcd);
        $display("test abort done");
    endtask : t_abort

    // short low resets, long low powers down
    task automatic t_pwd();
        powerdown_reset_n_i = 1'b0;
        repeat (20) @(negedge clk_i);
        powerdown_reset_n_i = 1'b1;
        repeat (6) @(negedge clk_i);
        chk_bit(data_valid_o, 1'b0);
        chk_bit(powered_down_o, 1'b0);
        prev = 14'h0000;
        conv_frame(1'b0, 14'h0777);
        powerdown_reset_n_i = 1'b0;
        repeat (1720) @(negedge clk_i);
        chk_bit(powered_down_o, 1'b0);
        repeat (120) @(negedge clk_i);
        chk_bit(powered_down_o, 1'b1);
        $display("test powerdown done");
    endtask : t_pwd

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    // watchdog well beyond the expected run
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        close_out();
    end

    // main sequence
    initial begin
        rst_i = 1'b1;
        powerdown_reset_n_i = 1'b1;
        conv_data_i = '0;
        prev = 14'h0000;
        {n_errors, n_tests, busy_cnt, last_busy} = '0;
        trk_seen = 1'b0;
        repeat (3) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (4) @(negedge clk_i);
        t_spi();
        t_dsp();
        t_short();
        t_abort(1'b0);
        t_abort(1'b1);
        t_pwd();
        close_out();
    end
endmodule : tb
`default_nettype wire
